/* File: cri_common_reset_irq_summary.sv */
// common reset control and clear-on-read interrupt summary registers
`timescale 1ns/100ps
`default_nettype none

module cri_common_reset_irq_summary (
    input wire logic clk,
    input wire logic reset,
    input wire logic [19:0] regAddress,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    output logic regReadValid,
    input wire logic fabricTransceiverResetIn,
    input wire logic transceiverIrq,
    input wire logic memctlOtherIrq,
    input wire logic memctlFifoIrq,
    input wire logic portBCore2Irq,
    input wire logic portBCore1Irq,
    input wire logic portACore2Irq,
    input wire logic portACore1Irq,
    input wire logic portBTxIrq,
    input wire logic portBRxIrq,
    input wire logic portATxIrq,
    input wire logic portARxIrq,
    input wire logic [3:0] bankIrq,
    output logic transceiverReset,
    output logic memctlSwReset,
    output logic portASwReset,
    output logic portBSwReset,
    output logic [6:0] spareCtrlBits,
    output logic forceInterrupt
);

    typedef struct packed {
        logic [7:0] blockResetControl;
        logic [7:0] spareAndForceControl;
        logic fabricResetMeta;
        logic fabricResetSync;
        logic transceiverReset;
        logic memctlSwReset;
        logic portASwReset;
        logic portBSwReset;
        logic [6:0] spareCtrlBits;
        logic forceInterrupt;
        logic [7:0] readData;
        logic readValid;
        cri_common_pkg::cri_bus_state_type busState;
    } cri_top_state_type;

    cri_top_state_type state;
    cri_top_state_type next_state;

    logic [15:0] flagSource;
    logic [15:0] flagValue;
    logic [15:0] flagClear;
    logic [7:0] coreSummary;
    logic [7:0] bufferSummary;
    logic readCore;
    logic readBuffer;
    logic forceOn;
    logic anyBank;

    // force comes from the registered control bit so it is glitch free
    assign forceOn = state.spareAndForceControl[
        cri_common_pkg::FORCE_INTERRUPT_BIT];
    assign anyBank = |bankIrq;

    // source of each core and buffer summary flag, force pushes every one active
    always_comb begin
        flagSource = '0;
        flagSource[cri_common_pkg::TRANSCEIVER_IRQ_BIT] =
            transceiverIrq || forceOn;
        flagSource[cri_common_pkg::MEMCTL_OTHER_IRQ_BIT] =
            memctlOtherIrq || forceOn;
        flagSource[cri_common_pkg::MEMCTL_FIFO_IRQ_BIT] =
            memctlFifoIrq || forceOn;
        flagSource[cri_common_pkg::BUFFER_BANK_IRQ_BIT] =
            anyBank || forceOn;
        flagSource[cri_common_pkg::PORT_B_CORE2_IRQ_BIT] =
            portBCore2Irq || forceOn;
        flagSource[cri_common_pkg::PORT_B_CORE1_IRQ_BIT] =
            portBCore1Irq || forceOn;
        flagSource[cri_common_pkg::PORT_A_CORE2_IRQ_BIT] =
            portACore2Irq || forceOn;
        flagSource[cri_common_pkg::PORT_A_CORE1_IRQ_BIT] =
            portACore1Irq || forceOn;
        // buffer summary flags sit in the upper byte of the flag vector
        flagSource[8 + cri_common_pkg::PORT_B_TX_IRQ_BIT] =
            portBTxIrq || forceOn;
        flagSource[8 + cri_common_pkg::PORT_B_RX_IRQ_BIT] =
            portBRxIrq || forceOn;
        flagSource[8 + cri_common_pkg::PORT_A_TX_IRQ_BIT] =
            portATxIrq || forceOn;
        flagSource[8 + cri_common_pkg::PORT_A_RX_IRQ_BIT] =
            portARxIrq || forceOn;
        // bank 0 lands in bit 7, bank 3 in bit 4
        for (int b = 0; b < cri_common_pkg::BANK_COUNT; b++) begin
            flagSource[8 + cri_common_pkg::BANK_IRQ_LSB + 3 - b] =
                bankIrq[b] || forceOn;
        end
    end

    // decode of reads that clear a summary register
    assign readCore = regRead && !regWrite &&
        (regAddress == cri_common_pkg::CORE_INTERRUPT_SUMMARY_ADDR);
    assign readBuffer = regRead && !regWrite &&
        (regAddress == cri_common_pkg::BUFFER_INTERRUPT_SUMMARY_ADDR);

    // one flag cell per summary bit; the read clears exactly what it sees
    genvar g;
    generate
        for (g = 0; g < cri_common_pkg::FLAG_COUNT; g++) begin : gen_flag
            // clear only bits the read returns as set
            assign flagClear[g] = ((g < 8) ? readCore : readBuffer) &&
                flagValue[g];
            cri_event_flag u_flag (
                .clk(clk),
                .reset(reset),
                .source(flagSource[g]),
                .readClear(flagClear[g]),
                .flag(flagValue[g])
            );
        end
    endgenerate

    assign coreSummary = flagValue[7:0];
    assign bufferSummary = flagValue[15:8];

    // register writes, reset outputs and read path
    always_comb begin
        next_state = state;
        next_state.readValid = 1'b0;

        // fabric reset arrives from another domain, two stages first
        next_state.fabricResetMeta = fabricTransceiverResetIn;
        next_state.fabricResetSync = state.fabricResetMeta;

        // writes; bits 0 to 3 of the reset control are reserved, kept zero
        if (regWrite) begin
            case (regAddress)
                cri_common_pkg::BLOCK_RESET_CONTROL_ADDR: begin
                    next_state.blockResetControl = {regWriteData[7:4], 4'h0};
                end
                cri_common_pkg::SPARE_AND_FORCE_CONTROL_ADDR: begin
                    next_state.spareAndForceControl = regWriteData;
                end
                default: begin
                    // summary and reserved registers ignore writes
                    next_state.readData = state.readData;
                end
            endcase
        end

        // either reset source alone holds the transceiver in reset
        next_state.transceiverReset = state.fabricResetSync ||
            state.blockResetControl[
                cri_common_pkg::TRANSCEIVER_HARD_RESET_BIT];
        next_state.memctlSwReset = state.blockResetControl[
            cri_common_pkg::MEMCTL_SW_RESET_BIT];
        next_state.portASwReset = state.blockResetControl[
            cri_common_pkg::PORT_A_SW_RESET_BIT];
        next_state.portBSwReset = state.blockResetControl[
            cri_common_pkg::PORT_B_SW_RESET_BIT];
        next_state.spareCtrlBits = state.spareAndForceControl[
            cri_common_pkg::SPARE_CTRL_MSB:
            cri_common_pkg::SPARE_CTRL_LSB];
        // cores use this level to force their own enabled status bits
        next_state.forceInterrupt = forceOn;

        // read answer one cycle after the request; write wins a collision
        case (state.busState)
            cri_common_pkg::CRI_BUS_IDLE: begin
                if (regRead && !regWrite) begin
                    next_state.busState = cri_common_pkg::CRI_BUS_ANSWER;
                    next_state.readValid = 1'b1;
                    case (regAddress)
                        cri_common_pkg::BLOCK_RESET_CONTROL_ADDR: begin
                            next_state.readData = state.blockResetControl;
                        end
                        cri_common_pkg::SPARE_AND_FORCE_CONTROL_ADDR: begin
                            next_state.readData = state.spareAndForceControl;
                        end
                        cri_common_pkg::RESERVED_COMMON_STATUS_ADDR: begin
                            next_state.readData =
                                cri_common_pkg::RESERVED_READ_VALUE;
                        end
                        cri_common_pkg::CORE_INTERRUPT_SUMMARY_ADDR: begin
                            next_state.readData = coreSummary;
                        end
                        cri_common_pkg::BUFFER_INTERRUPT_SUMMARY_ADDR: begin
                            next_state.readData = bufferSummary;
                        end
                        default: begin
                            next_state.readData =
                                cri_common_pkg::UNMAPPED_READ_VALUE;
                        end
                    endcase
                end
            end
            cri_common_pkg::CRI_BUS_ANSWER: begin
                // reads may follow back to back; the answer holds its data
                if (regRead && !regWrite) begin
                    next_state.readValid = 1'b1;
                    case (regAddress)
                        cri_common_pkg::BLOCK_RESET_CONTROL_ADDR: begin
                            next_state.readData = state.blockResetControl;
                        end
                        cri_common_pkg::SPARE_AND_FORCE_CONTROL_ADDR: begin
                            next_state.readData = state.spareAndForceControl;
                        end
                        cri_common_pkg::CORE_INTERRUPT_SUMMARY_ADDR: begin
                            next_state.readData = coreSummary;
                        end
                        cri_common_pkg::BUFFER_INTERRUPT_SUMMARY_ADDR: begin
                            next_state.readData = bufferSummary;
                        end
                        default: begin
                            next_state.readData =
                                cri_common_pkg::UNMAPPED_READ_VALUE;
                        end
                    endcase
                end else begin
                    next_state.busState = cri_common_pkg::CRI_BUS_IDLE;
                end
            end
            default: begin
                next_state.busState = cri_common_pkg::CRI_BUS_IDLE;
            end
        endcase
    end

    // all state but the flag cells in one register; reset puts every control to its quiet value
    always_ff @(posedge clk) begin
        if (reset) begin
            state.blockResetControl <=
                cri_common_pkg::BLOCK_RESET_CONTROL_RESET;
            state.spareAndForceControl <=
                cri_common_pkg::SPARE_AND_FORCE_CONTROL_RESET;
            state.fabricResetMeta <= 1'b0;
            state.fabricResetSync <= 1'b0;
            state.transceiverReset <= 1'b0;
            state.memctlSwReset <= 1'b0;
            state.portASwReset <= 1'b0;
            state.portBSwReset <= 1'b0;
            state.spareCtrlBits <= '0;
            state.forceInterrupt <= 1'b0;
            state.readData <= cri_common_pkg::SUMMARY_RESET;
            state.readValid <= 1'b0;
            state.busState <= cri_common_pkg::CRI_BUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // every output straight from a flip-flop
    assign regReadData = state.readData;
    assign regReadValid = state.readValid;
    assign transceiverReset = state.transceiverReset;
    assign memctlSwReset = state.memctlSwReset;
    assign portASwReset = state.portASwReset;
    assign portBSwReset = state.portBSwReset;
    assign spareCtrlBits = state.spareCtrlBits;
    assign forceInterrupt = state.forceInterrupt;

endmodule // cri_common_reset_irq_summary

`default_nettype wire

/* File: cri_common_pkg.sv */
// shared constants and types for the common reset and interrupt summary
package cri_common_pkg;

    // register bus geometry
    localparam int ADDR_WIDTH = 20;
    localparam int DATA_WIDTH = 8;

    // register byte addresses
    localparam logic [19:0] BLOCK_RESET_CONTROL_ADDR = 20'h3_0b20;
    localparam logic [19:0] SPARE_AND_FORCE_CONTROL_ADDR = 20'h3_0b21;
    localparam logic [19:0] RESERVED_COMMON_STATUS_ADDR = 20'h3_0b28;
    localparam logic [19:0] CORE_INTERRUPT_SUMMARY_ADDR = 20'h3_0b29;
    localparam logic [19:0] BUFFER_INTERRUPT_SUMMARY_ADDR = 20'h3_0b2a;

    // values after reset, and read values of reserved and unmapped addresses
    localparam logic [7:0] BLOCK_RESET_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SPARE_AND_FORCE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SUMMARY_RESET = 8'h00;
    localparam logic [7:0] RESERVED_READ_VALUE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // block reset control field positions
    localparam int TRANSCEIVER_HARD_RESET_BIT = 4;
    localparam int MEMCTL_SW_RESET_BIT = 5;
    localparam int PORT_A_SW_RESET_BIT = 6;
    localparam int PORT_B_SW_RESET_BIT = 7;

    // spare and force control field positions
    localparam int SPARE_CTRL_LSB = 0;
    localparam int SPARE_CTRL_MSB = 6;
    localparam int SPARE_CTRL_WIDTH = 7;
    localparam int FORCE_INTERRUPT_BIT = 7;

    // core interrupt summary field positions
    localparam int TRANSCEIVER_IRQ_BIT = 0;
    localparam int MEMCTL_OTHER_IRQ_BIT = 1;
    localparam int MEMCTL_FIFO_IRQ_BIT = 2;
    localparam int BUFFER_BANK_IRQ_BIT = 3;
    localparam int PORT_B_CORE2_IRQ_BIT = 4;
    localparam int PORT_B_CORE1_IRQ_BIT = 5;
    localparam int PORT_A_CORE2_IRQ_BIT = 6;
    localparam int PORT_A_CORE1_IRQ_BIT = 7;

    // buffer interrupt summary field positions
    localparam int PORT_B_TX_IRQ_BIT = 0;
    localparam int PORT_B_RX_IRQ_BIT = 1;
    localparam int PORT_A_TX_IRQ_BIT = 2;
    localparam int PORT_A_RX_IRQ_BIT = 3;
    localparam int BANK_IRQ_LSB = 4;
    localparam int BANK_COUNT = 4;

    // summary flags in total, core register first then buffer register
    localparam int FLAG_COUNT = 16;

    // register bus read path states
    typedef enum logic [1:0] {
        CRI_BUS_IDLE = 2'b01,
        CRI_BUS_ANSWER = 2'b10
    } cri_bus_state_type;

endpackage

/* File: cri_event_flag.sv */
// one clear-on-read summary flag that re-arms only after its source drops
`timescale 1ns/100ps
`default_nettype none

module cri_event_flag (
    input wire logic clk,
    input wire logic reset,
    input wire logic source,
    input wire logic readClear,
    output logic flag
);

    typedef struct packed {
        logic sourceSeen;
        logic flag;
    } cri_flag_state_type;

    cri_flag_state_type state;
    cri_flag_state_type next_state;
    logic rise;

    // a flag is raised by a fresh rising edge of its source only
    always_comb begin
        next_state = state;
        rise = source && !state.sourceSeen;
        next_state.sourceSeen = source;
        // set beats clear, so an edge in the read cycle stays pending
        next_state.flag = rise || (state.flag && !readClear);
    end

    // source held high after a read does not set the flag again
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;

endmodule // cri_event_flag

`default_nettype wire

/* File: cri_summary_assertions.sv */
// concurrent checks on the common reset and interrupt summary ports
`timescale 1ns/100ps
`default_nettype none

module cri_summary_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic [19:0] regAddress,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWriteData,
    input wire logic [7:0] regReadData,
    input wire logic regReadValid,
    input wire logic fabricTransceiverResetIn,
    input wire logic transceiverIrq,
    input wire logic [3:0] bankIrq,
    input wire logic transceiverReset,
    input wire logic memctlSwReset,
    input wire logic portASwReset,
    input wire logic portBSwReset,
    input wire logic [6:0] spareCtrlBits,
    input wire logic forceInterrupt
);
    logic rdCore;
    logic rdBuf;
    logic ctlWrite;
    logic spareWrite;

    // decoded accesses; a write in the same cycle wins over a read
    assign rdCore = regRead && !regWrite
        && regAddress == cri_common_pkg::CORE_INTERRUPT_SUMMARY_ADDR;
    assign rdBuf = regRead && !regWrite
        && regAddress == cri_common_pkg::BUFFER_INTERRUPT_SUMMARY_ADDR;
    assign ctlWrite = regWrite
        && regAddress == cri_common_pkg::BLOCK_RESET_CONTROL_ADDR;
    assign spareWrite = regWrite
        && regAddress == cri_common_pkg::SPARE_AND_FORCE_CONTROL_ADDR;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // outputs follow a write two edges later: register, then output flop
    a_sw_resets: assert property (ctlWrite |-> ##2
        {portBSwReset, portASwReset, memctlSwReset}
        == $past(regWriteData[7:5], 2)) else $error("soft resets wrong");
    a_spare_force: assert property (spareWrite |-> ##2
        {forceInterrupt, spareCtrlBits} == $past(regWriteData, 2))
        else $error("spare or force output wrong");
    a_hard_reset_bit: assert property (
        ctlWrite && regWriteData[4] |-> ##2 transceiverReset)
        else $error("hard reset bit ignored");
    // fabric input crosses a two-flop synchroniser, so allow a margin
    a_fabric_reset: assert property (
        fabricTransceiverResetIn [*5] |-> transceiverReset)
        else $error("fabric reset ignored");
    a_read_answer: assert property (rdCore |=> regReadValid)
        else $error("summary read not answered");
    // a source held high must not set its flag again after a read
    a_held_no_reset: assert property (
        (rdCore && transceiverIrq && $past(transceiverIrq))
        ##1 (rdCore && transceiverIrq) |=> !regReadData[0])
        else $error("held source set flag again");
    a_xcvr_flag_set: assert property (
        $rose(transceiverIrq) ##1 rdCore |=> regReadData[0])
        else $error("transceiver flag missing");
    a_bank_flag_set: assert property (
        $rose(|bankIrq) ##1 rdCore |=> regReadData[3])
        else $error("bank summary flag missing");
    // no buffer read between the edge and the checked read
    a_bank0_flag: assert property (
        $rose(bankIrq[0]) ##1 !rdBuf [*2] ##1 rdBuf |=> regReadData[7])
        else $error("bank 0 flag missing");
endmodule // cri_summary_checker

bind cri_common_reset_irq_summary cri_summary_checker u_checker (.*);

`default_nettype wire

/* File: cri_common_reset_irq_summary_test.sv */
// self-checking bench for the common reset and interrupt summary block
`timescale 1ns/100ps
`default_nettype none

module cri_common_reset_irq_summary_test;
    localparam logic [19:0] ctlAddr = cri_common_pkg::BLOCK_RESET_CONTROL_ADDR;
    localparam logic [19:0] spareAddr =
        cri_common_pkg::SPARE_AND_FORCE_CONTROL_ADDR;
    localparam logic [19:0] coreAddr =
        cri_common_pkg::CORE_INTERRUPT_SUMMARY_ADDR;
    localparam logic [19:0] bufAddr =
        cri_common_pkg::BUFFER_INTERRUPT_SUMMARY_ADDR;
    logic [19:0] badAddr [4] = '{20'h3_0b28, coreAddr, bufAddr, 20'h3_0b22};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [19:0] regAddress = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regWriteData = 8'h00;
    logic fabricTransceiverResetIn = 1'b0;
    logic [14:0] src = '0;
    logic [7:0] regReadData;
    logic regReadValid;
    logic transceiverReset;
    logic memctlSwReset;
    logic portASwReset;
    logic portBSwReset;
    logic [6:0] spareCtrlBits;
    logic forceInterrupt;
    int numErrors = 0;
    int nCompared = 0;

    // 40 MHz system bus clock
    always #12.5 clk = ~clk;

    // src bits: seven core sources, four buffer FIFOs, then banks 0 to 3
    cri_common_reset_irq_summary u_cri_common_reset_irq_summary (
        .clk(clk), .reset(reset), .regAddress(regAddress),
        .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
        .regReadData(regReadData), .regReadValid(regReadValid),
        .fabricTransceiverResetIn(fabricTransceiverResetIn),
        .transceiverIrq(src[0]), .memctlOtherIrq(src[1]),
        .memctlFifoIrq(src[2]), .portBCore2Irq(src[3]),
        .portBCore1Irq(src[4]), .portACore2Irq(src[5]),
        .portACore1Irq(src[6]), .portBTxIrq(src[7]), .portBRxIrq(src[8]),
        .portATxIrq(src[9]), .portARxIrq(src[10]), .bankIrq(src[14:11]),
        .transceiverReset(transceiverReset), .memctlSwReset(memctlSwReset),
        .portASwReset(portASwReset), .portBSwReset(portBSwReset),
        .spareCtrlBits(spareCtrlBits), .forceInterrupt(forceInterrupt)
    );

    task automatic finalReport();
        $display("compared %0d, errors %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] got);
        nCompared++;
        if (got !== e) begin
            numErrors++;
            $display("[ERR] %s expected %h seen %h", what, e, got);
        end
    endtask

    // both strobes are set by wr, rd and idle so back-to-back access is legal
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        regWrite = 1'b1;
        regRead = 1'b0;
        regAddress = a;
        regWriteData = d;
        tick();
    endtask

    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        regWrite = 1'b0;
        regRead = 1'b1;
        regAddress = a;
        tick();
        chk("readValid", 8'h01, {7'h00, regReadValid});
        chk("readData", e, regReadData);
    endtask

    task automatic idle(input int n);
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (n) tick();
    endtask

    task automatic chkResets(input logic [7:0] e);
        chk("resets", e, {4'h0, portBSwReset, portASwReset, memctlSwReset,
            transceiverReset});
    endtask

    // the synchroniser latency is not fixed, so poll with a bound
    task automatic waitXcvr(input logic v);
        for (int i = 0; i < 8 && transceiverReset !== v; i++) tick();
        chk("xcvrReset", {7'h00, v}, {7'h00, transceiverReset});
        if (transceiverReset !== v) finalReport();
    endtask

    // expected {buffer, core} summary for one source; a bank sets both
    function automatic logic [15:0] expFlags(input int i);
        logic [15:0] e;
        e = '0;
        if (i < 3) e[i] = 1'b1;
        else if (i < 11) e[i + 1] = 1'b1;
        else e[3] = 1'b1;
        if (i > 10) e[26 - i] = 1'b1;
        return e;
    endfunction

    // main sequence
    initial begin
        logic [15:0] e;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        rd(ctlAddr, 8'h00);
        rd(spareAddr, 8'h00);
        rd(coreAddr, 8'h00);
        rd(bufAddr, 8'h00);
        for (int i = 4; i < 8; i++) begin
            wr(ctlAddr, 8'h01 << i);
            idle(3);
            chkResets(8'h01 << (i - 4));
        end
        wr(ctlAddr, 8'hff);
        rd(ctlAddr, 8'hf0);
        wr(ctlAddr, 8'h00);
        idle(3);
        chkResets(8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(spareAddr, 8'h55 >> i);
            idle(3);
            chk("spare", 8'h55>>i, {forceInterrupt, spareCtrlBits});
            rd(spareAddr, 8'h55 >> i);
        end
        fabricTransceiverResetIn = 1'b1;
        waitXcvr(1'b1);
        fabricTransceiverResetIn = 1'b0;
        waitXcvr(1'b0);
        // every source alone: set, clear on read while held, then re-arm
        for (int i = 0; i < 15; i++) begin
            e = expFlags(i);
            src = 15'h0001 << i;
            tick();
            rd(coreAddr, e[7:0]);
            rd(coreAddr, 8'h00);
            rd(bufAddr, e[15:8]);
            rd(bufAddr, 8'h00);
            idle(1);
            src = '0;
            tick();
            src = 15'h0001 << i;
            tick();
            rd(coreAddr, e[7:0]);
            rd(bufAddr, e[15:8]);
            idle(1);
            src = '0;
            tick();
        end
        // a source rising during the read must survive to the next read
        src = 15'h0002;
        rd(coreAddr, 8'h00);
        rd(coreAddr, 8'h02);
        // a fresh edge in the read cycle of a set flag must stay pending
        src = '0;
        idle(1);
        src = 15'h0002;
        idle(1);
        src = '0;
        idle(1);
        src = 15'h0002;
        rd(coreAddr, 8'h02);
        rd(coreAddr, 8'h02);
        rd(coreAddr, 8'h00);
        idle(1);
        src = '0;
        wr(spareAddr, 8'h80);
        idle(3);
        chk("force", 8'h80, {forceInterrupt, spareCtrlBits});
        rd(coreAddr, 8'hff);
        rd(coreAddr, 8'h00);
        rd(bufAddr, 8'hff);
        wr(spareAddr, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(badAddr[i], 8'hff);
            rd(badAddr[i], 8'h00);
        end
        // a read strobe beside a write is ignored and the write lands
        regWrite = 1'b1;
        regRead = 1'b1;
        regAddress = ctlAddr;
        regWriteData = 8'h10;
        tick();
        chk("collideValid", 8'h00, {7'h00, regReadValid});
        rd(ctlAddr, 8'h10);
        // reset in mid-run must clear the control registers
        wr(ctlAddr, 8'hf0);
        wr(spareAddr, 8'h7f);
        idle(1);
        reset = 1'b1;
        repeat (2) tick();
        reset = 1'b0;
        rd(ctlAddr, 8'h00);
        rd(spareAddr, 8'h00);
        idle(2);
        chkResets(8'h00);
        finalReport();
    end
endmodule // cri_common_reset_irq_summary_test

`default_nettype wire
